// ---- hdl/gpd_params.svh ----
// Constants for the port data register bank.
// Assumes a word-addressed Avalon-MM slave, byte address = 4 x index.
`ifndef GPD_PARAMS_SVH
`define GPD_PARAMS_SVH
`define GPD_NPORTS 5
`define GPD_IDX_PORT0 3'h0
`define GPD_IDX_PORT1 3'h1
`define GPD_IDX_PORT2 3'h2
`define GPD_IDX_PORT3 3'h3
`define GPD_IDX_PORT4 3'h4
`define GPD_DATA_RST 8'h00
`define GPD_P4_MASK 8'h0F
`define GPD_BIT_DMINUS 1
`define GPD_BIT_DPLUS 0
`define GPD_BIT_REGULATOR_OUTPUT 2
`define GPD_ALT_P0_MASK 8'h7F
`define GPD_ALT_P1_MASK 8'h78
`endif

// ---- hdl/gpd_pkg.sv ----
// Types shared by the port data register bank.
// Assumes the params header is included by the users as needed.
package gpd_pkg;
  // One byte-wide port's pin controls
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpd_drive_t;
  // Bus access phase
  typedef enum logic [1:0] {
    GPD_IDLE,
    GPD_ANSWER
  } gpd_bus_state_t;
endpackage : gpd_pkg

// ---- hdl/gpd_pin_mux.sv ----
// Per-port pin driver: output enable, open drain and alternate override.
// Assumes configuration inputs are synchronous to clk.
`timescale 1ns/1ps
module gpd_pin_mux (
  input wire logic [7:0] dataBits,
  input wire logic [7:0] gpioOe,
  input wire logic [7:0] openDrain,
  input wire logic [7:0] altSel,
  input wire logic [7:0] altOut,
  input wire logic [7:0] altOe,
  input wire logic [7:0] present,
  output gpd_pkg::gpd_drive_t drive
);
  // Combine data, enables and alternate functions per bit
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!present[i]) begin
        // Absent pin never drives
        drive.out[i] = 1'b0;
        drive.oe[i] = 1'b1;
      end else if (altSel[i]) begin
        // Alternate function owns the pin
        drive.out[i] = altOut[i];
        drive.oe[i] = ~altOe[i];
      end else if (openDrain[i]) begin
        drive.out[i] = 1'b0;
        drive.oe[i] = ~(gpioOe[i] & ~dataBits[i]);
      end else begin
        drive.out[i] = dataBits[i];
        drive.oe[i] = ~gpioOe[i];
      end
    end
  end
endmodule : gpd_pin_mux

// ---- hdl/gpd_port_data.sv ----
// Port data register bank for five byte ports with Avalon-MM access.
// Assumes pins are synchronous to clk; pinOe_n is active low, enable inputs active high.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "gpd_params.svh"
module gpd_port_data #(
  // Per-port implemented bit masks (variant dependent)
  parameter logic [39:0] PRESENT = 40'h0F_FF_FF_FF_FF,
  // Variant where regulator pin only works in USB mode
  parameter bit REGULATOR_OUTPUT_USB_ONLY = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [39:0] pinIn,
  output logic [39:0] pinOut,
  output logic [39:0] pinOe_n,
  input wire logic [39:0] gpioOe,
  input wire logic [39:0] openDrain,
  input wire logic [7:0] port0AltSel,
  input wire logic [7:0] port0AltOut,
  input wire logic [7:0] port0AltOe,
  input wire logic [7:0] spiAltSel,
  input wire logic [7:0] spiAltOut,
  input wire logic [7:0] spiAltOe,
  input wire logic vregEnable,
  input wire logic usbMode,
  input wire logic usbForce,
  input wire logic [1:0] usbOut,
  input wire logic usbOe
);
  // Data registers
  logic [7:0] portData_r [`GPD_NPORTS];
  // Bus state
  gpd_pkg::gpd_bus_state_t busState_r;
  logic [7:0] p1AltSel;
  logic [7:0] p1AltOut;
  logic [7:0] p1AltOe;
  logic vregActive;
  gpd_pkg::gpd_drive_t drv [`GPD_NPORTS];

  // Implemented-bit mask of a port
  function automatic logic [7:0] portMask(input logic [2:0] idx);
    logic [7:0] m;
    m = PRESENT[8*idx +: 8];
    if (idx == `GPD_IDX_PORT4) begin
      m = m & `GPD_P4_MASK;
    end
    return m;
  endfunction : portMask

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `GPD_NPORTS; i++) begin
        portData_r[i] <= `GPD_DATA_RST;
      end
    end else if (avs_write && busState_r == gpd_pkg::GPD_ANSWER) begin
      if (avs_address < 3'(`GPD_NPORTS)) begin
        portData_r[avs_address] <= avs_writedata[7:0] & portMask(avs_address);
      end
    end
  end

  // One wait state: answer on second cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busState_r <= gpd_pkg::GPD_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (busState_r)
        gpd_pkg::GPD_IDLE: begin
          if (avs_read || avs_write) begin
            busState_r <= gpd_pkg::GPD_ANSWER;
            avs_waitrequest <= 1'b0;
          end else begin
            avs_waitrequest <= 1'b1;
          end
        end
        default: begin
          busState_r <= gpd_pkg::GPD_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && busState_r == gpd_pkg::GPD_IDLE) begin
      if (avs_address < 3'(`GPD_NPORTS)) begin
        avs_readdata <= {24'h00_0000, pinIn[8*avs_address +: 8] & portMask(avs_address)};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  assign vregActive = vregEnable & (~REGULATOR_OUTPUT_USB_ONLY | usbMode);

  // Port1 alternate selection: SPI, regulator, USB
  always_comb begin
    p1AltSel = spiAltSel & `GPD_ALT_P1_MASK;
    p1AltOut = spiAltOut;
    p1AltOe = spiAltOe;
    // Regulator output is not a logic drive; pin released
    if (vregActive) begin
      p1AltSel[`GPD_BIT_REGULATOR_OUTPUT] = 1'b1;
      p1AltOe[`GPD_BIT_REGULATOR_OUTPUT] = 1'b0;
    end
    if (usbMode) begin
      p1AltSel[`GPD_BIT_DMINUS] = 1'b1;
      p1AltSel[`GPD_BIT_DPLUS] = 1'b1;
      if (usbForce) begin
        p1AltOut[`GPD_BIT_DMINUS] = portData_r[1][`GPD_BIT_DMINUS];
        p1AltOut[`GPD_BIT_DPLUS] = portData_r[1][`GPD_BIT_DPLUS];
        p1AltOe[`GPD_BIT_DMINUS] = 1'b1;
        p1AltOe[`GPD_BIT_DPLUS] = 1'b1;
      end else begin
        p1AltOut[`GPD_BIT_DMINUS] = usbOut[1];
        p1AltOut[`GPD_BIT_DPLUS] = usbOut[0];
        p1AltOe[`GPD_BIT_DMINUS] = usbOe;
        p1AltOe[`GPD_BIT_DPLUS] = usbOe;
      end
    end
  end

  // Pin drivers per port
  for (genvar p = 0; p < `GPD_NPORTS; p++) begin : gPort
    logic [7:0] aSel;
    logic [7:0] aOut;
    logic [7:0] aOe;
    assign aSel = (p == 0) ? (port0AltSel & `GPD_ALT_P0_MASK) : (p == 1) ? p1AltSel : 8'h00;
    assign aOut = (p == 0) ? port0AltOut : (p == 1) ? p1AltOut : 8'h00;
    assign aOe = (p == 0) ? port0AltOe : (p == 1) ? p1AltOe : 8'h00;
    gpd_pin_mux uMux (
      .dataBits(portData_r[p]),
      .gpioOe(gpioOe[8*p +: 8]),
      .openDrain(openDrain[8*p +: 8]),
      .altSel(aSel),
      .altOut(aOut),
      .altOe(aOe),
      .present(portMask(3'(p))),
      .drive(drv[p])
    );
  end

  // Registered pin outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinOut <= 40'h00_0000_0000;
      pinOe_n <= 40'hFF_FFFF_FFFF;
    end else begin
      for (int p = 0; p < `GPD_NPORTS; p++) begin
        pinOut[8*p +: 8] <= drv[p].out;
        pinOe_n[8*p +: 8] <= drv[p].oe;
      end
    end
  end

  AST_ONE_WAIT: assert property (@(posedge clk) disable iff (!resetn)
    (busState_r == gpd_pkg::GPD_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest)
    else $error("bus answer not after one cycle");
  AST_P4_RSVD: assert property (@(posedge clk) disable iff (!resetn)
    portData_r[4][7:4] == 4'h0)
    else $error("port4 reserved bits set");
  AST_NO_OE: assert property (@(posedge clk) disable iff (!resetn)
    (gpioOe[16] == 1'b0 && usbMode == 1'b0) |=> pinOe_n[16])
    else $error("pin driven without enable");
  AST_FORCE: assert property (@(posedge clk) disable iff (!resetn)
    (usbMode && usbForce) |=> (!pinOe_n[8] && pinOut[8] == $past(portData_r[1][0])))
    else $error("force state not driven");
  AST_OD: assert property (@(posedge clk) disable iff (!resetn)
    (openDrain[28] && portData_r[3][4] && PRESENT[28]) |=> pinOe_n[28])
    else $error("open drain one driven");
  AST_READ: assert property (@(posedge clk) disable iff (!resetn)
    (avs_read && avs_address == 3'h2 && busState_r == gpd_pkg::GPD_IDLE)
    |=> avs_readdata[7:0] == ($past(pinIn[23:16]) & PRESENT[23:16]))
    else $error("read is not pin level");
  AST_REGULATOR_OUTPUT: assert property (@(posedge clk) disable iff (!resetn)
    (vregEnable && !REGULATOR_OUTPUT_USB_ONLY) |=> pinOe_n[10])
    else $error("regulator pin driven as gpio");
  AST_WRITE: assert property (@(posedge clk) disable iff (!resetn)
    (avs_write && !avs_waitrequest && avs_address == 3'h3 && PRESENT[31])
    |=> portData_r[3][7] == $past(avs_writedata[7]))
    else $error("write not stored");
endmodule : gpd_port_data

// ---- verification/gpd_pin_board.sv ----
// Board model of the five ports: resolves each pin level for the bank.
// Assumes pinOe_n is active low and every pin has a pull-up to the rail.
`timescale 1ns/1ps
module gpd_pin_board (
  input wire logic [39:0] pinOut,
  input wire logic [39:0] pinOe_n,
  input wire logic [39:0] extVal,
  input wire logic [39:0] extEn,
  output logic [39:0] pinIn
);
  // driver wins, else board, else pull-up
  always_comb begin
    for (int i = 0; i < 40; i++) begin
      if (!pinOe_n[i]) begin
        pinIn[i] = pinOut[i];
      end else if (extEn[i]) begin
        pinIn[i] = extVal[i];
      end else begin
        pinIn[i] = 1'b1;
      end
    end
  end
endmodule : gpd_pin_board

// ---- verification/testbench.sv ----
// Self-checking bench for the port data bank over Avalon-MM.
// Assumes one wait state per access and pins settling within three cycles.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %0t got %h expected %h", $time, g, e); end end
module testbench;
  logic clk, resetn, rd, wr, wreq, vregEnable, usbMode, usbForce, usbOe;
  logic [2:0] addr;
  logic [31:0] wdata, rdata;
  logic [39:0] pinOut, pinOe_n, pinIn, gpioOe, openDrain, extVal, extEn;
  logic [7:0] altSel, altOut, altOe, spiSel, spiOut, spiOe;
  logic [1:0] usbOut;
  int fail_count, checks_done;
  gpd_port_data uut (.clk(clk), .resetn(resetn), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n), .gpioOe(gpioOe),
    .openDrain(openDrain), .port0AltSel(altSel), .port0AltOut(altOut),
    .port0AltOe(altOe), .spiAltSel(spiSel), .spiAltOut(spiOut), .spiAltOe(spiOe),
    .vregEnable(vregEnable), .usbMode(usbMode), .usbForce(usbForce), .usbOut(usbOut),
    .usbOe(usbOe));
  gpd_pin_board board (.pinOut(pinOut), .pinOe_n(pinOe_n), .extVal(extVal),
    .extEn(extEn), .pinIn(pinIn));
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h00_0000, d};
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (wreq !== 1'b0) begin
      fail_count++;
      stop_test();
    end
  endtask : bus
  task automatic wrp(input logic [2:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wrp
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(q, {24'h00_0000, e})
  endtask : chk_rd
  // Pins follow data one cycle late; allow margin
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask : settle
  // After reset nothing drives, reads show pulled-up pins
  task automatic t_reset;
    `CHK(pinOe_n, 40'hFF_FFFF_FFFF)
    `CHK(pinOut, 40'h00_0000_0000)
    chk_rd(3'h0, 8'hFF);
  endtask : t_reset
  // Driven ports read back, absent and unmapped bits read zero
  task automatic t_rw;
    logic [7:0] v [4] = '{8'hA5, 8'h5A, 8'hC3, 8'h3C};
    gpioOe <= 40'hFF_FFFF_FFFF;
    for (int p = 0; p < 4; p++) wrp(p[2:0], v[p]);
    wrp(3'h4, 8'hFF);
    wrp(3'h5, 8'hFF);
    settle();
    for (int p = 0; p < 4; p++) chk_rd(p[2:0], v[p]);
    chk_rd(3'h4, 8'h0F);
    `CHK(pinOe_n[39:36], 4'hF)
    chk_rd(3'h5, 8'h00);
  endtask : t_rw
  // Undriven pins report the board level, not the register
  task automatic t_ext;
    gpioOe <= 40'h00_0000_0000;
    extEn <= 40'hFF_FFFF_FFFF;
    extVal <= 40'h00_0096_0000;
    settle();
    `CHK(pinOe_n, 40'hFF_FFFF_FFFF)
    chk_rd(3'h2, 8'h96);
    extEn <= 40'h00_0000_0000;
    gpioOe <= 40'hFF_FFFF_FFFF;
  endtask : t_ext
  // Open drain floats ones and pulls zeros low
  task automatic t_od;
    openDrain <= 40'hFF_FFFF_FFFF;
    wrp(3'h3, 8'hF0);
    settle();
    `CHK(pinOe_n[31:24], 8'hF0)
    `CHK(pinOut[27:24], 4'h0)
    openDrain <= 40'h00_0000_0000;
  endtask : t_od
  // USB engine owns D lines, force lets data bits drive them
  task automatic t_usb;
    usbMode <= 1'b1;
    usbOe <= 1'b1;
    usbOut <= 2'b01;
    settle();
    `CHK(pinOut[9:8], 2'b01)
    usbForce <= 1'b1;
    wrp(3'h1, 8'h02);
    settle();
    `CHK(pinOut[9:8], 2'b10)
    usbMode <= 1'b0;
    usbForce <= 1'b0;
    usbOe <= 1'b0;
    settle();
    `CHK(pinOut[9:8], 2'b10)
  endtask : t_usb
  // Regulator and alternate functions take over their pins
  task automatic t_alt;
    vregEnable <= 1'b1;
    altSel <= 8'h67;
    altOut <= 8'h42;
    altOe <= 8'h42;
    spiSel <= 8'h08;
    spiOut <= 8'h08;
    spiOe <= 8'h08;
    settle();
    `CHK(pinOe_n[10], 1'b1)
    `CHK(pinOut[1], 1'b1)
    `CHK(pinOut[11], 1'b1)
    `CHK(pinOut[6], 1'b1)
    `CHK(pinOe_n[5], 1'b1)
    `CHK(pinOe_n[2], 1'b1)
    `CHK(pinOe_n[0], 1'b1)
    vregEnable <= 1'b0;
    settle();
    `CHK(pinOe_n[10], 1'b0)
  endtask : t_alt
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Main sequence
  initial begin
    {resetn, rd, wr, vregEnable, usbMode, usbForce, usbOe} = '0;
    {addr, wdata, usbOut} = '0;
    {gpioOe, openDrain, extVal, extEn} = '0;
    {altSel, altOut, altOe, spiSel, spiOut, spiOe} = '0;
    fail_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_rw();
    t_ext();
    t_od();
    t_usb();
    t_alt();
    stop_test();
  end
endmodule : testbench
